// ---- include/sfm_pkg.sv ----
/*
  Shared constants and types of the status and fault monitor: register offsets,
  field positions, reset values and the persistence and extension times.
  Assumes a 125 MHz core clock.
*/
package sfm_pkg;

  localparam int unsigned CLK_PERIOD_PS = 8000;

  // Register offsets, one byte each
  localparam logic [15:0] ADDR_CONFIG      = 16'h0400;
  localparam logic [15:0] ADDR_SOURCE_SEL  = 16'h0401;
  localparam logic [15:0] ADDR_IRQ_ENABLE  = 16'h0402;
  localparam logic [15:0] ADDR_OUT_DISABLE = 16'h0403;
  localparam logic [15:0] ADDR_LIVE        = 16'h0404;
  localparam logic [15:0] ADDR_STICKY      = 16'h0405;
  localparam logic [15:0] ADDR_FATAL       = 16'h0406;

  // Fields of status_config
  localparam int CFG_FILTER_LSB = 0;
  localparam int CFG_LONG_BIT   = 3;
  localparam int CFG_ENC_BIT    = 4;
  localparam int CFG_ENZ_BIT    = 5;
  localparam int CFG_USED_BITS  = 6;

  // Persistence filter codes
  localparam logic [2:0] FILT_NONE  = 3'h0;
  localparam logic [2:0] FILT_10US  = 3'h1;
  localparam logic [2:0] FILT_150US = 3'h2;
  localparam logic [2:0] FILT_2M5S  = 3'h3;
  localparam logic [2:0] FILT_40MS  = 3'h4;

  // Reset values
  localparam logic [7:0] RST_REG8  = 8'h00;
  localparam logic [5:0] RST_CFG   = 6'h00;

  // Times in ns as specified, and their cycle counts (least times round up)
  localparam longint unsigned T10US_NS  = 64'd10000;
  localparam longint unsigned T150US_NS = 64'd150000;
  localparam longint unsigned T2M5S_NS  = 64'd2500000;
  localparam longint unsigned T40MS_NS  = 64'd40000000;
  localparam longint unsigned CYC10US   = (T10US_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned CYC150US  = (T150US_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned CYC2M5S   = (T2M5S_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned CYC40MS   = (T40MS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Alarm level codes above this are unusable
  localparam logic [7:0] ALARM_CODE_MAX = 8'h80;

  typedef struct packed {
    logic internalError;
    logic nvmDoubleBitError;
    logic nvmChecksumError;
  } sfm_fatal_t;

endpackage

// ---- hw/sfm_status_fault_monitor.sv ----
/*
  Status and fault monitor: persistence filtering, live and sticky status,
  source selection, interrupt and output-disable generation, fatal errors.
  Assumes condition inputs come from logic on core_clk and a byte register port.
*/
`timescale 1ns/1ps

module sfm_status_fault_monitor
  import sfm_pkg::*;
#(
  parameter int unsigned CNT10US  = 32'(CYC10US),
  parameter int unsigned CNT150US = 32'(CYC150US),
  parameter int unsigned CNT2M5S  = 32'(CYC2M5S),
  parameter int unsigned CNT40MS  = 32'(CYC40MS),
  parameter int unsigned IRQ_EXT  = 32'(CYC40MS)
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  input  wire logic        pathSaturated,
  input  wire logic [7:0]  inputFreqCode,
  input  wire logic [7:0]  alarmLevel,
  input  wire logic        lagExceeded,
  input  wire logic        rateLimited,
  input  wire logic        lagFatal,
  input  wire logic [11:0] amplitude,
  input  wire logic [11:0] amplitudeLow,
  input  wire logic [11:0] amplitudeHigh,
  input  wire logic        adaptLimitHit,
  input  wire logic        residueHit,
  input  wire logic        counterOverflow,
  input  wire logic        captureEvent,
  input  wire sfm_fatal_t  fatalIn,
  output logic             fault_interrupt_n,
  output logic             quadrature_index_outputs_disable,
  output logic             quadrature_index_outputs_invalid,
  output logic             smoothingBypass,
  output logic             haltOperation
);

  localparam int CW = $clog2(CNT40MS + 1);
  localparam int EW = $clog2(IRQ_EXT + 1);

  // The built-in checks look eight cycles deep, so shorter counts are refused
  if (CNT10US < 8 || CNT150US < CNT10US
      || CNT2M5S < CNT150US || CNT40MS < CNT2M5S) begin
    $error("Persistence counts must be at least 8 and ascending");
  end
  if (IRQ_EXT < 8) begin
    $error("Interrupt extension must be at least 8 cycles");
  end

  logic [5:0]  cfg_q;
  logic [7:0]  sel_q;
  logic [7:0]  ie_q;
  logic [7:0]  hiz_q;
  logic [7:0]  live_q;
  wire logic [7:0] live_d;
  logic [7:0]  sticky_q;
  logic [7:0]  sticky_d;
  sfm_fatal_t  fatal_q;
  logic [EW-1:0] hold_q;
  logic [EW-1:0] hold_d;
  logic [7:0]  rdData_q;
  logic        irqN_q;
  logic        hiz_o_q;
  logic        invalid_q;
  logic        bypass_q;
  logic        halt_q;

  // Raw conditions in status bit order
  wire logic        freqAlarm = (alarmLevel <= ALARM_CODE_MAX)
                                && (inputFreqCode > alarmLevel);
  wire logic        ampBad    = (amplitude < amplitudeLow)
                                || (amplitude > amplitudeHigh);
  wire logic [7:0]  rawCond   = {residueHit,
                                 adaptLimitHit,
                                 ampBad,
                                 lagFatal,
                                 rateLimited,
                                 lagExceeded,
                                 freqAlarm,
                                 pathSaturated};

  wire logic [2:0]  filtCode  = cfg_q[CFG_FILTER_LSB +: 3];
  wire logic        longMode  = cfg_q[CFG_LONG_BIT];
  // Reserved filter codes behave as no filtering
  wire logic [CW-1:0] filtLimit =
    (filtCode == FILT_10US)  ? CW'(CNT10US)  :
    (filtCode == FILT_150US) ? CW'(CNT150US) :
    (filtCode == FILT_2M5S)  ? CW'(CNT2M5S)  :
    (filtCode == FILT_40MS)  ? CW'(CNT40MS)  : CW'(0);

  wire logic wrCfg    = regWrEn && (regAddr == ADDR_CONFIG);
  wire logic wrSel    = regWrEn && (regAddr == ADDR_SOURCE_SEL);
  wire logic wrIe     = regWrEn && (regAddr == ADDR_IRQ_ENABLE);
  wire logic wrHiz    = regWrEn && (regAddr == ADDR_OUT_DISABLE);
  wire logic wrSticky = regWrEn && (regAddr == ADDR_STICKY);

  // Per condition persistence counter; saturates so long filters need no wrap guard
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_filt
      logic [CW-1:0] cnt_q;
      wire  logic [CW-1:0] cnt_d = !rawCond[gi] ? CW'(0) :
                                   (cnt_q >= filtLimit) ? cnt_q : cnt_q + CW'(1);
      assign live_d[gi] = rawCond[gi] && (cnt_q >= filtLimit);
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_d;
        end
      end
    end
  endgenerate

  // Writing 1 keeps a bit; a new live event wins over a clear
  wire logic [7:0] keepMask = wrSticky ? regWrData : 8'hff;
  assign sticky_d = (sticky_q & keepMask) | live_q;

  wire logic [7:0] selSrc  = (sel_q & sticky_q) | (~sel_q & live_q);
  wire logic       anyFatal = |fatal_q;
  wire logic       irqSrc  = (|(selSrc & ie_q))
                             || (cfg_q[CFG_ENC_BIT] && counterOverflow)
                             || (cfg_q[CFG_ENZ_BIT] && captureEvent)
                             || anyFatal;
  wire logic       hizSrc  = (|(selSrc & hiz_q)) || anyFatal;

  assign hold_d = !longMode ? EW'(0) :
                  irqSrc ? EW'(IRQ_EXT) :
                  (hold_q != EW'(0)) ? hold_q - EW'(1) : EW'(0);

  wire logic [7:0] rdMux =
    (regAddr == ADDR_CONFIG)      ? {2'b00, cfg_q} :
    (regAddr == ADDR_SOURCE_SEL)  ? sel_q :
    (regAddr == ADDR_IRQ_ENABLE)  ? ie_q :
    (regAddr == ADDR_OUT_DISABLE) ? hiz_q :
    (regAddr == ADDR_LIVE)        ? live_q :
    (regAddr == ADDR_STICKY)      ? sticky_q :
    (regAddr == ADDR_FATAL)       ? {5'b00000, fatal_q} : 8'h00;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= RST_CFG;
      sel_q <= RST_REG8;
      ie_q  <= RST_REG8;
      hiz_q <= RST_REG8;
    end else begin
      if (wrCfg) cfg_q <= regWrData[CFG_USED_BITS-1:0];
      if (wrSel) sel_q <= regWrData;
      if (wrIe)  ie_q  <= regWrData;
      if (wrHiz) hiz_q <= regWrData;
    end
  end

  // Fatal errors are only ever set; only power-on reset clears them
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      live_q   <= RST_REG8;
      sticky_q <= RST_REG8;
      fatal_q  <= '0;
      hold_q   <= '0;
    end else begin
      live_q   <= live_d;
      sticky_q <= sticky_d;
      fatal_q  <= fatal_q | fatalIn;
      hold_q   <= hold_d;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q  <= 8'h00;
      irqN_q    <= 1'b1;
      hiz_o_q   <= 1'b0;
      invalid_q <= 1'b0;
      bypass_q  <= 1'b0;
      halt_q    <= 1'b0;
    end else begin
      if (regRdEn) rdData_q <= rdMux;
      irqN_q    <= !(irqSrc || (hold_q != EW'(0)));
      hiz_o_q   <= hizSrc;
      invalid_q <= live_q[4] || anyFatal;
      bypass_q  <= live_q[2];
      // Same edge as the fatal flops, so halt does not lag the error
      halt_q    <= |(fatal_q | fatalIn);
    end
  end

  assign regRdData                        = rdData_q;
  assign fault_interrupt_n                = irqN_q;
  assign quadrature_index_outputs_disable = hiz_o_q;
  assign quadrature_index_outputs_invalid = invalid_q;
  assign smoothingBypass                  = bypass_q;
  assign haltOperation                    = halt_q;

  property p_live_follows;
    @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> ((live_q & ~$past(rawCond)) == 8'h00);
  endproperty
  a_live_follows: assert property (p_live_follows)
    else $error("Live bit set without its condition");

  property p_filter_10us;
    @(posedge core_clk) disable iff (!reset_n)
      ($rose(live_q[0]) && filtCode == FILT_10US) |-> $past(rawCond[0], 8);
  endproperty
  a_filter_10us: assert property (p_filter_10us)
    else $error("Live bit rose before condition persisted");

  property p_sticky_catch;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(live_q[1]) |=> sticky_q[1] [*2];
  endproperty
  a_sticky_catch: assert property (p_sticky_catch)
    else $error("Sticky bit missed a live event");

  property p_sticky_keep_one;
    @(posedge core_clk) disable iff (!reset_n)
      (wrSticky && regWrData[3] && sticky_q[3]) |=> sticky_q[3];
  endproperty
  a_sticky_keep_one: assert property (p_sticky_keep_one)
    else $error("Writing one cleared a sticky bit");

  property p_irq_fatal;
    @(posedge core_clk) disable iff (!reset_n)
      (|fatalIn) |=> ##1 (!fault_interrupt_n && quadrature_index_outputs_disable);
  endproperty
  a_irq_fatal: assert property (p_irq_fatal)
    else $error("Fatal error did not interrupt and disable outputs");

  property p_irq_short;
    @(posedge core_clk) disable iff (!reset_n)
      (!irqSrc && !longMode && hold_q == EW'(0)) |=> fault_interrupt_n;
  endproperty
  a_irq_short: assert property (p_irq_short)
    else $error("Interrupt active with no source");

  property p_irq_long;
    @(posedge core_clk) disable iff (!reset_n)
      (longMode && $fell(irqSrc)) |=> (!fault_interrupt_n) [*8];
  endproperty
  a_irq_long: assert property (p_irq_long)
    else $error("Interrupt not prolonged");

  property p_overflow_irq;
    @(posedge core_clk) disable iff (!reset_n)
      (counterOverflow && cfg_q[CFG_ENC_BIT]) |=> !fault_interrupt_n;
  endproperty
  a_overflow_irq: assert property (p_overflow_irq)
    else $error("Counter overflow did not interrupt");

  property p_capture_irq;
    @(posedge core_clk) disable iff (!reset_n)
      (captureEvent && cfg_q[CFG_ENZ_BIT]) |=> !fault_interrupt_n;
  endproperty
  a_capture_irq: assert property (p_capture_irq)
    else $error("Capture event did not interrupt");

  property p_hiz_sel;
    @(posedge core_clk) disable iff (!reset_n)
      (|(sel_q & sticky_q & hiz_q)) |=> quadrature_index_outputs_disable;
  endproperty
  a_hiz_sel: assert property (p_hiz_sel)
    else $error("Selected sticky source did not disable outputs");

  property p_fatal_ro;
    @(posedge core_clk) disable iff (!reset_n)
      (regWrEn && regAddr == ADDR_FATAL) |=> (fatal_q == ($past(fatal_q) | $past(fatalIn)));
  endproperty
  a_fatal_ro: assert property (p_fatal_ro)
    else $error("Fatal register changed by a write");

  property p_lag_bypass;
    @(posedge core_clk) disable iff (!reset_n)
      (live_q[2] && !live_q[4] && !anyFatal) |=>
        (smoothingBypass && !quadrature_index_outputs_invalid);
  endproperty
  a_lag_bypass: assert property (p_lag_bypass)
    else $error("Lag did not bypass smoothing");

  c_sticky_clear: cover property (@(posedge core_clk) disable iff (!reset_n)
    sticky_q[0] ##1 (wrSticky && !regWrData[0]) ##1 !sticky_q[0]);
  c_irq_ext: cover property (@(posedge core_clk) disable iff (!reset_n)
    longMode && $fell(irqSrc) ##8 !fault_interrupt_n);
  c_hiz_live: cover property (@(posedge core_clk) disable iff (!reset_n)
    !quadrature_index_outputs_disable ##1 quadrature_index_outputs_disable);
  c_fatal: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(haltOperation));

endmodule

// ---- bench/sfm_host_monitor.sv ----
/*
  Host-side model of the controller watching the fault interrupt line.
  Assumes the line is a registered level on core_clk, driven by the monitor.
*/
`timescale 1ns/1ps
module sfm_host_monitor (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        fault_interrupt_n,
  output logic      [15:0] lowEvents,
  output logic      [15:0] lastLow
);
  logic [15:0] runLen;

  // A low run is counted only when it ends, so one-cycle pulses count too
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      runLen    <= 16'h0000;
      lowEvents <= 16'h0000;
      lastLow   <= 16'h0000;
    end else if (!fault_interrupt_n) begin
      runLen <= runLen + 16'h0001;
    end else if (runLen != 16'h0000) begin
      lastLow   <= runLen;
      lowEvents <= lowEvents + 16'h0001;
      runLen    <= 16'h0000;
    end
  end
endmodule

// ---- bench/sfm_status_fault_monitor_tb.sv ----
/*
  Self-checking bench of the status and fault monitor with a host model.
  Assumes shortened persistence and extension counts of 10/20/30/40/10 cycles.
*/
`timescale 1ns/1ps
module sfm_status_fault_monitor_tb;
  import sfm_pkg::*;
  localparam int IRQ_X = 10;
  logic core_clk = 1'b0, reset_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
  logic [15:0] regAddr = 16'h0000, lowEvents, lastLow;
  logic [7:0] regWrData = 8'h00, regRdData, inputFreqCode = 8'h00, alarmLevel = 8'h80;
  logic pathSaturated = 1'b0, lagExceeded = 1'b0, rateLimited = 1'b0, lagFatal = 1'b0;
  logic adaptLimitHit = 1'b0, residueHit = 1'b0, counterOverflow = 1'b0, captureEvent = 1'b0;
  logic [11:0] amplitude = 12'h096, amplitudeLow = 12'h064, amplitudeHigh = 12'h0c8;
  sfm_fatal_t fatalIn = '0;
  logic irqN, outDis, outInv, bypass, halt;
  int errors = 0, num_checks = 0, ev;

  always #4 core_clk = ~core_clk;

  sfm_status_fault_monitor #(.CNT10US(10), .CNT150US(20), .CNT2M5S(30), .CNT40MS(40),
    .IRQ_EXT(IRQ_X)) i_dut (.core_clk(core_clk), .reset_n(reset_n), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .pathSaturated(pathSaturated), .inputFreqCode(inputFreqCode), .alarmLevel(alarmLevel),
    .lagExceeded(lagExceeded), .rateLimited(rateLimited), .lagFatal(lagFatal),
    .amplitude(amplitude), .amplitudeLow(amplitudeLow), .amplitudeHigh(amplitudeHigh),
    .adaptLimitHit(adaptLimitHit), .residueHit(residueHit), .counterOverflow(counterOverflow),
    .captureEvent(captureEvent), .fatalIn(fatalIn), .fault_interrupt_n(irqN),
    .quadrature_index_outputs_disable(outDis), .quadrature_index_outputs_invalid(outInv),
    .smoothingBypass(bypass), .haltOperation(halt));

  sfm_host_monitor i_host (.core_clk(core_clk), .reset_n(reset_n), .fault_interrupt_n(irqN),
    .lowEvents(lowEvents), .lastLow(lastLow));

  task tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Strobes drop one cycle before the next request so no signal is set twice at one edge
  task wr(input logic [15:0] a, input logic [7:0] d);
    regAddr = a; regWrData = d; regWrEn = 1'b1; tick(1); regWrEn = 1'b0; tick(1);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    regAddr = a; regRdEn = 1'b1; tick(1); regRdEn = 1'b0; tick(1); chk(regRdData, e);
  endtask
  task rst();
    reset_n = 1'b0; tick(2); reset_n = 1'b1; tick(1);
  endtask
  task cond(input int i, input logic v);
    case (i)
      0: pathSaturated = v;
      1: inputFreqCode = v ? 8'h81 : 8'h00;
      2: lagExceeded = v;
      3: rateLimited = v;
      4: lagFatal = v;
      5: amplitude = v ? 12'h0c9 : 12'h096;
      6: adaptLimitHit = v;
      default: residueHit = v;
    endcase
  endtask

  task t_regs();
    for (int a = 0; a < 8; a++) rd(16'h0400 + 16'(a), 8'h00);
    wr(ADDR_CONFIG, 8'hff); rd(ADDR_CONFIG, 8'h3f);
    wr(ADDR_SOURCE_SEL, 8'ha5); rd(ADDR_SOURCE_SEL, 8'ha5);
    wr(ADDR_IRQ_ENABLE, 8'h5a); rd(ADDR_IRQ_ENABLE, 8'h5a);
    wr(ADDR_OUT_DISABLE, 8'hc3); rd(ADDR_OUT_DISABLE, 8'hc3);
    wr(ADDR_LIVE, 8'hff); rd(ADDR_LIVE, 8'h00);
    wr(ADDR_FATAL, 8'hff); rd(ADDR_FATAL, 8'h00);
    wr(16'h0407, 8'hff); rd(16'h0407, 8'h00);
    rst();
  endtask
  task t_live();
    for (int i = 0; i < 8; i++) begin
      cond(i, 1'b1); tick(2);
      rd(ADDR_LIVE, 8'h01 << i);
      if (i == 2) chk(8'(bypass), 8'h01);
      if (i == 4) chk(8'(outInv), 8'h01);
      cond(i, 1'b0); tick(2); rd(ADDR_LIVE, 8'h00);
    end
    rd(ADDR_STICKY, 8'hff);
    wr(ADDR_STICKY, 8'hfe); rd(ADDR_STICKY, 8'hfe);
    wr(ADDR_STICKY, 8'h00); rd(ADDR_STICKY, 8'h00);
    // A clear written while the condition stands must lose to the live bit
    cond(0, 1'b1); tick(2);
    wr(ADDR_STICKY, 8'h00); rd(ADDR_STICKY, 8'h01);
    cond(0, 1'b0); tick(2); wr(ADDR_STICKY, 8'h00); rd(ADDR_STICKY, 8'h00);
  endtask
  task t_thresh();
    alarmLevel = 8'd100; inputFreqCode = 8'd100; tick(2); rd(ADDR_LIVE, 8'h00);
    inputFreqCode = 8'd101; tick(2); rd(ADDR_LIVE, 8'h02);
    alarmLevel = 8'd129; inputFreqCode = 8'd200; tick(2); rd(ADDR_LIVE, 8'h00);
    alarmLevel = 8'h80; inputFreqCode = 8'h00;
    amplitude = 12'd99; tick(2); rd(ADDR_LIVE, 8'h20);
    amplitude = 12'd100; tick(2); rd(ADDR_LIVE, 8'h00);
    amplitude = 12'd200; tick(2); rd(ADDR_LIVE, 8'h00);
    amplitude = 12'd201; tick(2); rd(ADDR_LIVE, 8'h20);
    amplitude = 12'h096; tick(2); wr(ADDR_STICKY, 8'h00);
  endtask
  task t_filter();
    for (int c = 1; c < 5; c++) begin
      wr(ADDR_CONFIG, 8'(c));
      cond(0, 1'b1); tick(5 * c); rd(ADDR_LIVE, 8'h00);
      tick(10 * c); rd(ADDR_LIVE, 8'h01);
      cond(0, 1'b0); tick(2);
    end
    // Reserved code filters nothing
    wr(ADDR_CONFIG, 8'h05); cond(0, 1'b1); tick(2); rd(ADDR_LIVE, 8'h01);
    cond(0, 1'b0); tick(2);
    wr(ADDR_CONFIG, 8'h00); wr(ADDR_STICKY, 8'h00);
  endtask
  task t_route();
    wr(ADDR_IRQ_ENABLE, 8'h01); wr(ADDR_OUT_DISABLE, 8'h01);
    cond(0, 1'b1); tick(3); chk({irqN, outDis}, 8'h01);
    cond(0, 1'b0); tick(3); chk({irqN, outDis}, 8'h02);
    // Sticky cleared first so the pulse below is the only thing latched
    wr(ADDR_STICKY, 8'h00); wr(ADDR_SOURCE_SEL, 8'h01);
    chk({irqN, outDis}, 8'h02);
    cond(0, 1'b1); tick(1); cond(0, 1'b0); tick(4);
    chk({irqN, outDis}, 8'h01);
    wr(ADDR_STICKY, 8'h00); tick(3); chk({irqN, outDis}, 8'h02);
    wr(ADDR_IRQ_ENABLE, 8'h00); wr(ADDR_OUT_DISABLE, 8'h00);
    cond(0, 1'b1); tick(3); chk({irqN, outDis}, 8'h02);
    cond(0, 1'b0); wr(ADDR_SOURCE_SEL, 8'h00); wr(ADDR_STICKY, 8'h00);
  endtask
  task t_long();
    wr(ADDR_IRQ_ENABLE, 8'h01); wr(ADDR_CONFIG, 8'h08);
    cond(0, 1'b1); tick(2); cond(0, 1'b0); tick(5); chk(8'(irqN), 8'h00);
    tick(IRQ_X + 6); chk(8'(irqN), 8'h01);
    // Two cycles of live source plus the full extension
    chk(lastLow[7:0], 8'(IRQ_X + 2));
    wr(ADDR_IRQ_ENABLE, 8'h00); wr(ADDR_CONFIG, 8'h00); wr(ADDR_STICKY, 8'h00);
  endtask
  task t_events();
    for (int k = 0; k < 2; k++) begin
      for (int en = 0; en < 2; en++) begin
        wr(ADDR_CONFIG, en ? 8'h10 << k : 8'h00); ev = int'(lowEvents);
        if (k == 0) counterOverflow = 1'b1; else captureEvent = 1'b1;
        tick(1); counterOverflow = 1'b0; captureEvent = 1'b0; tick(3);
        chk(8'(int'(lowEvents) - ev), 8'(en));
        if (en == 1) chk(lastLow[7:0], 8'h01);
      end
    end
    wr(ADDR_CONFIG, 8'h00);
  endtask
  task t_fatal();
    for (int b = 0; b < 3; b++) begin
      rst(); fatalIn = sfm_fatal_t'(3'(1 << b)); tick(1); fatalIn = '0; tick(3);
      rd(ADDR_FATAL, 8'h01 << b);
      chk({4'h0, halt, irqN, outDis, outInv}, 8'h0b);
      wr(ADDR_FATAL, 8'h00); rd(ADDR_FATAL, 8'h01 << b);
    end
    rst();
  endtask

  task print_verdict();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    tick(2); reset_n = 1'b1; tick(1);
    t_regs();
    t_live();
    t_thresh();
    t_filter();
    t_route();
    t_long();
    t_events();
    t_fatal();
    print_verdict();
  end
  // Whole sequence needs about 500 cycles; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    print_verdict();
  end
endmodule
